/* switch_debug_link_pkg.sv */
package switch_debug_link_pkg;

    localparam int NUM_LINKS = 8;
    localparam int NUM_TILES = 2;

    // Register numbers
    localparam logic [7:0] DBG_CFG_TILE0_OFF = 8'h10;
    localparam logic [7:0] DBG_CFG_TILE1_OFF = 8'h11;
    localparam logic [7:0] DBG_ORIGIN_OFF = 8'h1F;
    localparam logic [7:0] LINK_STATUS_BASE = 8'h20;
    localparam logic [7:0] PROCESSOR_LINK_STATUS_NETWORK_BASE = 8'h40;
    localparam logic [7:0] LINK_CFG_BASE = 8'h80;

    // Debug configuration and origin fields
    localparam int DBG_DRIVE_EN_BIT = 0;
    localparam int DBG_REQ_EN_BIT = 1;
    localparam int ORIGIN_TILE0_BIT = 0;
    localparam int ORIGIN_TILE1_BIT = 1;
    localparam int ORIGIN_PIN_BIT = 4;

    // Link status fields
    localparam int TARGET_LSB = 24;
    localparam int DEST_LSB = 16;
    localparam int DIR_LSB = 8;
    localparam int NET_LSB = 4;
    localparam int JUNK_BIT = 2;
    localparam int DEST_BUSY_BIT = 1;
    localparam int SRC_BUSY_BIT = 0;

    // Link configuration fields
    localparam int CFG_ENABLE_BIT = 31;
    localparam int CFG_WIDE_BIT = 30;
    localparam int CFG_RX_ERR_BIT = 27;
    localparam int CFG_CREDIT_ISSUED_BIT = 26;
    localparam int CFG_CREDIT_HELD_BIT = 25;
    localparam int CFG_CREDIT_RESET_BIT = 24;
    localparam int CFG_RX_RESET_BIT = 23;
    localparam int CFG_SYM_GAP_LSB = 11;
    localparam int CFG_TOK_GAP_LSB = 0;

    // Reset values
    localparam logic [1:0] DBG_CFG_RESET = 2'h0;
    localparam logic [2:0] ORIGIN_RESET = 3'h0;
    localparam logic [3:0] DIR_RESET = 4'h0;
    localparam logic [1:0] NET_RESET = 2'h0;
    localparam logic [10:0] GAP_RESET = 11'h000;
    localparam logic ENABLE_RESET = 1'b0;
    localparam logic WIDE_RESET = 1'b0;

    // Low byte of a reply identifier that asks for no reply to a write
    localparam logic [7:0] REPLY_SUPPRESS = 8'hFF;

    typedef struct packed {
        logic [1:0] target_kind;
        logic [7:0] dest_link;
        logic junk;
        logic dest_busy;
        logic src_busy;
    } link_status_type;

    typedef struct packed {
        logic rx_error;
        logic credit_issued;
        logic credit_held;
    } ext_link_status_type;

    typedef struct packed {
        logic enable;
        logic wide;
        logic [10:0] symbol_gap;
        logic [10:0] token_gap;
        logic [3:0] direction;
        logic [1:0] network;
    } link_ctrl_type;

    typedef struct packed {
        logic req_en;
        logic drive_en;
    } debug_cfg_type;

    typedef struct packed {
        logic valid;
        logic write;
        logic [7:0] reg_num;
        logic [31:0] wdata;
        logic [23:0] reply_id;
    } reg_request_type;

    typedef struct packed {
        logic valid;
        logic [31:0] rdata;
        logic [23:0] reply_id;
    } reg_reply_type;

endpackage

/* switch_debug_link_config_regs.sv */
`timescale 1ns/100ps
`default_nettype none
module switch_debug_link_config_regs
    import switch_debug_link_pkg::*;
#(
    parameter int LINKS = NUM_LINKS
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Register access messages
    input wire reg_request_type req_in,
    output reg_reply_type reply_out,
    // Debug line
    input wire logic [NUM_TILES-1:0] core_halted_flag_in,
    output logic [NUM_TILES-1:0] debug_request_out,
    input wire logic debug_pin_n_in,
    output logic debug_pin_n_out,
    output logic debug_pin_n_oe_out,
    // Switch link state
    input wire link_status_type [LINKS-1:0] switch_link_status_in,
    input wire link_status_type [LINKS-1:0] processor_link_status_in,
    input wire ext_link_status_type [LINKS-1:0] ext_link_status_in,
    // Link control
    output link_ctrl_type [LINKS-1:0] link_ctrl_out,
    output logic [1:0] processor_link_network_out [LINKS],
    output logic [LINKS-1:0] credit_reset_out,
    output logic [LINKS-1:0] rx_reset_out
);

    debug_cfg_type [NUM_TILES-1:0] dbg_cfg_reg, dbg_cfg_next;
    logic [2:0] origin_reg, origin_next;
    link_ctrl_type [LINKS-1:0] ctrl_reg, ctrl_next;
    logic [1:0] processor_link_target_net_reg [LINKS];
    logic [1:0] processor_link_target_net_next [LINKS];
    logic [LINKS-1:0] credit_reset_reg, credit_reset_next;
    logic [LINKS-1:0] rx_reset_reg, rx_reset_next;
    reg_reply_type reply_reg, reply_next;
    logic [NUM_TILES-1:0] debug_request_reg, debug_request_next;
    logic pin_sync1_reg, pin_sync2_reg;
    logic drive_reg, drive_next;
    logic [1:0] drive_hist_reg;
    logic line_prev_reg;

    logic [NUM_TILES-1:0] tile_drive;
    logic ext_active;
    logic line_active;
    logic line_rise;
    logic [7:0] switch_link_target_idx, processor_link_target_idx, cfg_idx;
    logic in_switch_link_target, in_processor_link_target, in_cfg;
    logic [31:0] switch_link_target_word [LINKS];
    logic [31:0] processor_link_target_word [LINKS];
    logic [31:0] cfg_word [LINKS];
    logic [31:0] rdata;
    logic do_write;

    // Tile halted flags onto the line, pin is open drain
    always_comb begin
        for (int t = 0; t < NUM_TILES; t++) begin
            tile_drive[t] = dbg_cfg_reg[t].drive_en & core_halted_flag_in[t];
        end
    end

    // Our own pull-down comes back through the synchroniser two cycles late, so it is masked with the same delay
    assign ext_active = ~pin_sync2_reg & ~drive_hist_reg[1] & ~drive_reg;
    assign line_active = (|tile_drive) | ~pin_sync2_reg;
    assign line_rise = line_active & ~line_prev_reg;
    assign drive_next = |tile_drive;

    always_comb begin
        for (int t = 0; t < NUM_TILES; t++) begin
            debug_request_next[t] = line_active & dbg_cfg_reg[t].req_en;
        end
    end

    // Per-link decode
    assign switch_link_target_idx = 8'(req_in.reg_num - LINK_STATUS_BASE);
    assign processor_link_target_idx = 8'(req_in.reg_num - PROCESSOR_LINK_STATUS_NETWORK_BASE);
    assign cfg_idx = 8'(req_in.reg_num - LINK_CFG_BASE);
    assign in_switch_link_target = (req_in.reg_num >= LINK_STATUS_BASE) && (switch_link_target_idx < 8'(LINKS));
    assign in_processor_link_target = (req_in.reg_num >= PROCESSOR_LINK_STATUS_NETWORK_BASE) && (processor_link_target_idx < 8'(LINKS));
    assign in_cfg = (req_in.reg_num >= LINK_CFG_BASE) && (cfg_idx < 8'(LINKS));
    assign do_write = req_in.valid & req_in.write;

    genvar g;
    generate
        for (g = 0; g < LINKS; g++) begin : g_word
            always_comb begin
                switch_link_target_word[g] = 32'h0000_0000;
                switch_link_target_word[g][TARGET_LSB +: 2] = switch_link_status_in[g].target_kind;
                switch_link_target_word[g][DEST_LSB +: 8] = switch_link_status_in[g].dest_link;
                switch_link_target_word[g][DIR_LSB +: 4] = ctrl_reg[g].direction;
                switch_link_target_word[g][NET_LSB +: 2] = ctrl_reg[g].network;
                switch_link_target_word[g][JUNK_BIT] = switch_link_status_in[g].junk;
                switch_link_target_word[g][DEST_BUSY_BIT] = switch_link_status_in[g].dest_busy;
                switch_link_target_word[g][SRC_BUSY_BIT] = switch_link_status_in[g].src_busy;

                processor_link_target_word[g] = 32'h0000_0000;
                processor_link_target_word[g][TARGET_LSB +: 2] = processor_link_status_in[g].target_kind;
                processor_link_target_word[g][DEST_LSB +: 8] = processor_link_status_in[g].dest_link;
                processor_link_target_word[g][NET_LSB +: 2] = processor_link_target_net_reg[g];
                processor_link_target_word[g][JUNK_BIT] = processor_link_status_in[g].junk;
                processor_link_target_word[g][DEST_BUSY_BIT] = processor_link_status_in[g].dest_busy;
                processor_link_target_word[g][SRC_BUSY_BIT] = processor_link_status_in[g].src_busy;

                cfg_word[g] = 32'h0000_0000;
                cfg_word[g][CFG_ENABLE_BIT] = ctrl_reg[g].enable;
                cfg_word[g][CFG_WIDE_BIT] = ctrl_reg[g].wide;
                cfg_word[g][CFG_RX_ERR_BIT] = ext_link_status_in[g].rx_error;
                cfg_word[g][CFG_CREDIT_ISSUED_BIT] = ext_link_status_in[g].credit_issued;
                cfg_word[g][CFG_CREDIT_HELD_BIT] = ext_link_status_in[g].credit_held;
                cfg_word[g][CFG_SYM_GAP_LSB +: 11] = ctrl_reg[g].symbol_gap;
                cfg_word[g][CFG_TOK_GAP_LSB +: 11] = ctrl_reg[g].token_gap;
            end
        end
    endgenerate

    // Read multiplexer; unmapped numbers read as zero
    always_comb begin
        rdata = 32'h0000_0000;
        if (req_in.reg_num == DBG_CFG_TILE0_OFF) begin
            rdata[1:0] = dbg_cfg_reg[0];
        end else if (req_in.reg_num == DBG_CFG_TILE1_OFF) begin
            rdata[1:0] = dbg_cfg_reg[1];
        end else if (req_in.reg_num == DBG_ORIGIN_OFF) begin
            rdata[ORIGIN_PIN_BIT] = origin_reg[2];
            rdata[ORIGIN_TILE1_BIT] = origin_reg[1];
            rdata[ORIGIN_TILE0_BIT] = origin_reg[0];
        end else if (in_switch_link_target) begin
            rdata = switch_link_target_word[switch_link_target_idx[2:0]];
        end else if (in_processor_link_target) begin
            rdata = processor_link_target_word[processor_link_target_idx[2:0]];
        end else if (in_cfg) begin
            rdata = cfg_word[cfg_idx[2:0]];
        end
    end

    // Next state of the debug configuration, origin, link control, reset strobe and reply registers
    always_comb begin
        dbg_cfg_next = dbg_cfg_reg;
        origin_next = origin_reg;
        ctrl_next = ctrl_reg;
        processor_link_target_net_next = processor_link_target_net_reg;
        credit_reset_next = '0;
        rx_reset_next = '0;
        reply_next = '0;

        if (req_in.valid) begin
            reply_next.valid = ~(req_in.write && (req_in.reply_id[7:0] == REPLY_SUPPRESS));
            reply_next.reply_id = req_in.reply_id;
            reply_next.rdata = req_in.write ? 32'h0000_0000 : rdata;
        end

        if (do_write) begin
            if (req_in.reg_num == DBG_CFG_TILE0_OFF) begin
                dbg_cfg_next[0] = req_in.wdata[1:0];
            end else if (req_in.reg_num == DBG_CFG_TILE1_OFF) begin
                dbg_cfg_next[1] = req_in.wdata[1:0];
            end else if (req_in.reg_num == DBG_ORIGIN_OFF) begin
                origin_next = {req_in.wdata[ORIGIN_PIN_BIT], req_in.wdata[ORIGIN_TILE1_BIT],
                               req_in.wdata[ORIGIN_TILE0_BIT]};
            end else if (in_switch_link_target) begin
                ctrl_next[switch_link_target_idx[2:0]].direction = req_in.wdata[DIR_LSB +: 4];
                ctrl_next[switch_link_target_idx[2:0]].network = req_in.wdata[NET_LSB +: 2];
            end else if (in_processor_link_target) begin
                processor_link_target_net_next[processor_link_target_idx[2:0]] = req_in.wdata[NET_LSB +: 2];
            end else if (in_cfg) begin
                ctrl_next[cfg_idx[2:0]].enable = req_in.wdata[CFG_ENABLE_BIT];
                ctrl_next[cfg_idx[2:0]].wide = req_in.wdata[CFG_WIDE_BIT];
                ctrl_next[cfg_idx[2:0]].symbol_gap = req_in.wdata[CFG_SYM_GAP_LSB +: 11];
                ctrl_next[cfg_idx[2:0]].token_gap = req_in.wdata[CFG_TOK_GAP_LSB +: 11];
                credit_reset_next[cfg_idx[2:0]] = req_in.wdata[CFG_CREDIT_RESET_BIT];
                rx_reset_next[cfg_idx[2:0]] = req_in.wdata[CFG_RX_RESET_BIT];
            end
        end

        // A new line event overrides a software write in the same cycle
        if (line_rise) begin
            origin_next = {ext_active, tile_drive[1], tile_drive[0]};
        end
    end

    // Synchroniser starts at the idle high level so reset release sees no false line edge
    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            pin_sync1_reg <= 1'b1;
            pin_sync2_reg <= 1'b1;
        end else begin
            pin_sync1_reg <= debug_pin_n_in;
            pin_sync2_reg <= pin_sync1_reg;
        end
        if (rst_in) begin
            for (int t = 0; t < NUM_TILES; t++) begin
                dbg_cfg_reg[t] <= DBG_CFG_RESET;
            end
            origin_reg <= ORIGIN_RESET;
            for (int i = 0; i < LINKS; i++) begin
                ctrl_reg[i].enable <= ENABLE_RESET;
                ctrl_reg[i].wide <= WIDE_RESET;
                ctrl_reg[i].symbol_gap <= GAP_RESET;
                ctrl_reg[i].token_gap <= GAP_RESET;
                ctrl_reg[i].direction <= DIR_RESET;
                ctrl_reg[i].network <= NET_RESET;
                processor_link_target_net_reg[i] <= NET_RESET;
            end
            credit_reset_reg <= '0;
            rx_reset_reg <= '0;
            reply_reg <= '0;
            debug_request_reg <= '0;
            drive_reg <= 1'b0;
            drive_hist_reg <= 2'h0;
            line_prev_reg <= 1'b0;
        end else begin
            dbg_cfg_reg <= dbg_cfg_next;
            origin_reg <= origin_next;
            ctrl_reg <= ctrl_next;
            processor_link_target_net_reg <= processor_link_target_net_next;
            credit_reset_reg <= credit_reset_next;
            rx_reset_reg <= rx_reset_next;
            reply_reg <= reply_next;
            debug_request_reg <= debug_request_next;
            drive_reg <= drive_next;
            drive_hist_reg <= {drive_hist_reg[0], drive_reg};
            line_prev_reg <= line_active;
        end
    end

    assign reply_out = reply_reg;
    assign debug_request_out = debug_request_reg;
    assign debug_pin_n_out = 1'b0;
    assign debug_pin_n_oe_out = drive_reg;
    assign link_ctrl_out = ctrl_reg;
    assign processor_link_network_out = processor_link_target_net_reg;
    assign credit_reset_out = credit_reset_reg;
    assign rx_reset_out = rx_reset_reg;

endmodule
`default_nettype wire

/* switch_debug_link_config_regs_sva.sv */
`timescale 1ns/100ps
`default_nettype none
module switch_debug_link_config_regs_chk
    import switch_debug_link_pkg::*;
#(
    parameter int LINKS = NUM_LINKS
) (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Watched ports
    input wire reg_request_type req_in,
    input wire reg_reply_type reply_out,
    input wire logic [NUM_TILES-1:0] core_halted_flag_in,
    input wire logic debug_pin_n_out,
    input wire logic debug_pin_n_oe_out,
    input wire link_status_type [LINKS-1:0] switch_link_status_in,
    input wire link_ctrl_type [LINKS-1:0] link_ctrl_out,
    input wire logic [1:0] processor_link_network_out [LINKS],
    input wire logic [LINKS-1:0] credit_reset_out,
    input wire logic [LINKS-1:0] rx_reset_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    sequence s_wr(n);
        req_in.valid && req_in.write && req_in.reg_num == n;
    endsequence
    sequence s_rd(n);
        req_in.valid && !req_in.write && req_in.reg_num == n;
    endsequence
    property p_read_reply;
        req_in.valid && !req_in.write |=> reply_out.valid && reply_out.reply_id == $past(req_in.reply_id);
    endproperty
    a_read_reply: assert property (p_read_reply) else $error("read reply missing or wrong id");
    property p_suppress;
        req_in.valid && req_in.write && req_in.reply_id[7:0] == REPLY_SUPPRESS |=> !reply_out.valid;
    endproperty
    a_suppress: assert property (p_suppress) else $error("suppressed write replied");
    property p_no_req;
        !req_in.valid |=> !reply_out.valid;
    endproperty
    a_no_req: assert property (p_no_req) else $error("reply without request");
    property p_cfg0;
        s_wr(LINK_CFG_BASE) |=> link_ctrl_out[0].enable == $past(req_in.wdata[31])
            && link_ctrl_out[0].wide == $past(req_in.wdata[30]) && link_ctrl_out[0].token_gap == $past(req_in.wdata[10:0]);
    endproperty
    a_cfg0: assert property (p_cfg0) else $error("link 0 config not stored");
    property p_net0;
        s_wr(LINK_STATUS_BASE) |=> link_ctrl_out[0].direction == $past(req_in.wdata[11:8])
            && link_ctrl_out[0].network == $past(req_in.wdata[5:4]);
    endproperty
    a_net0: assert property (p_net0) else $error("link 0 direction or network not stored");
    property p_pnet0;
        s_wr(PROCESSOR_LINK_STATUS_NETWORK_BASE) |=> processor_link_network_out[0] == $past(req_in.wdata[5:4]);
    endproperty
    a_pnet0: assert property (p_pnet0) else $error("processor link 0 network not stored");
    property p_strobe;
        |credit_reset_out || |rx_reset_out |-> $past(req_in.valid && req_in.write && |req_in.wdata[24:23]);
    endproperty
    a_strobe: assert property (p_strobe) else $error("strobe without write");
    property p_credit3;
        s_wr(8'h83) ##0 req_in.wdata[24] |=> credit_reset_out[3];
    endproperty
    a_credit3: assert property (p_credit3) else $error("credit reset strobe missing");
    property p_rx2;
        s_wr(8'h82) ##0 req_in.wdata[23] |=> rx_reset_out[2];
    endproperty
    a_rx2: assert property (p_rx2) else $error("receiver reset strobe missing");
    property p_stat0;
        s_rd(LINK_STATUS_BASE) |=> reply_out.rdata[31:16] == {6'h00, $past(switch_link_status_in[0].target_kind),
            $past(switch_link_status_in[0].dest_link)};
    endproperty
    a_stat0: assert property (p_stat0) else $error("link 0 status read wrong");
    property p_unmapped;
        s_rd(8'h88) |=> reply_out.rdata == 32'h00000000;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_oe;
        debug_pin_n_oe_out |-> $past(|core_halted_flag_in) && !debug_pin_n_out;
    endproperty
    a_oe: assert property (p_oe) else $error("debug line driven without halted tile");
endmodule
bind switch_debug_link_config_regs switch_debug_link_config_regs_chk #(.LINKS(LINKS)) switch_debug_link_config_regs_chk_i (
    .clk_in(clk_in), .rst_in(rst_in), .req_in(req_in), .reply_out(reply_out),
    .core_halted_flag_in(core_halted_flag_in), .debug_pin_n_out(debug_pin_n_out),
    .debug_pin_n_oe_out(debug_pin_n_oe_out), .switch_link_status_in(switch_link_status_in),
    .link_ctrl_out(link_ctrl_out), .processor_link_network_out(processor_link_network_out),
    .credit_reset_out(credit_reset_out), .rx_reset_out(rx_reset_out));
`default_nettype wire

/* remote_link_partner.sv */
`timescale 1ns/100ps
`default_nettype none
module remote_link_partner
    import switch_debug_link_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // From the switch
    input wire link_ctrl_type [7:0] link_ctrl_in,
    input wire logic [7:0] credit_reset_in,
    // Towards the switch
    output link_status_type [7:0] switch_link_status_out,
    output link_status_type [7:0] processor_link_status_out,
    output ext_link_status_type [7:0] ext_link_status_out
);
    logic [7:0] credit_reg, credit_next, greeting_token_reg, greeting_token_next;
    always_comb begin
        credit_next = credit_reg;
        greeting_token_next = 8'h00;
        for (int k = 0; k < 8; k++) begin
            // Credit comes back one cycle after the greeting lands, never at once
            if (credit_reset_in[k]) begin
                credit_next[k] = 1'b0;
                greeting_token_next[k] = 1'b1;
            end else if (greeting_token_reg[k]) begin
                credit_next[k] = 1'b1;
            end
            switch_link_status_out[k] = {2'(k), 8'(8'hA0 + k), k[0], k[1], k[2]};
            processor_link_status_out[k] = {2'h1, 8'(8'h50 + k), ~k[0], ~k[1], ~k[2]};
            ext_link_status_out[k] = {k[0], link_ctrl_in[k].enable, credit_reg[k]};
        end
    end
    always_ff @(posedge clk_in) begin
        credit_reg <= rst_in ? 8'h00 : credit_next;
        greeting_token_reg <= rst_in ? 8'h00 : greeting_token_next;
    end
endmodule
`default_nettype wire

/* tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin $display("[FAIL] %s exp %h got %h", nm, exp, got); err_count++; end end
module tb_top
    import switch_debug_link_pkg::*;
;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    reg_request_type req = '0;
    reg_reply_type reply;
    logic [1:0] halted = 2'h0;
    logic ext_n = 1'b1;
    logic pin_n, pin_drv, pin_oe, got;
    logic [1:0] dbg_req;
    link_status_type [7:0] sw_st, pl_st;
    ext_link_status_type [7:0] ext_st;
    link_ctrl_type [7:0] ctrl;
    logic [1:0] pl_net [8];
    logic [7:0] cr_rst, rx_rst;
    logic [31:0] rdat;
    logic [15:0] pls;
    int err_count = 0;
    int cmp_count = 0;
    // Open-drain line: the block pulls low, otherwise the outside pin decides
    assign pin_n = pin_oe ? pin_drv : ext_n;
    switch_debug_link_config_regs switch_debug_link_config_regs_i (.clk_in(clk_in), .rst_in(rst_in),
        .req_in(req), .reply_out(reply), .core_halted_flag_in(halted), .debug_request_out(dbg_req),
        .debug_pin_n_in(pin_n), .debug_pin_n_out(pin_drv), .debug_pin_n_oe_out(pin_oe),
        .switch_link_status_in(sw_st), .processor_link_status_in(pl_st), .ext_link_status_in(ext_st),
        .link_ctrl_out(ctrl), .processor_link_network_out(pl_net), .credit_reset_out(cr_rst), .rx_reset_out(rx_rst));
    remote_link_partner remote_link_partner_i (.clk_in(clk_in), .rst_in(rst_in), .link_ctrl_in(ctrl),
        .credit_reset_in(cr_rst), .switch_link_status_out(sw_st), .processor_link_status_out(pl_st),
        .ext_link_status_out(ext_st));
    initial begin
        forever #20 clk_in = ~clk_in;
    end
    task automatic tally_and_finish;
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic access(input logic wr, input logic [7:0] num, input logic [31:0] dat, input logic [23:0] rid);
        @(negedge clk_in);
        req = '{1'b1, wr, num, dat, rid};
        @(negedge clk_in);
        req.valid = 1'b0;
        rdat = reply.rdata;
        got = reply.valid;
        pls = {cr_rst, rx_rst};
    endtask
    task automatic rd(input logic [7:0] num, input logic [31:0] exp);
        access(1'b0, num, 32'h00000000, 24'h000100);
        `CHK("reply", 1'b1, got)
        `CHK("rdata", exp, rdat)
    endtask
    task automatic wr(input logic [7:0] num, input logic [31:0] dat);
        access(1'b1, num, dat, 24'h000200);
        `CHK("wreply", 1'b1, got)
    endtask
    function automatic logic [31:0] sw_word(input int k, input logic [3:0] d, input logic [1:0] n);
        return {6'h00, 2'(k), 8'(8'hA0 + k), 4'h0, d, 2'h0, n, 1'b0, k[0], k[1], k[2]};
    endfunction
    function automatic logic [31:0] pl_word(input int k, input logic [1:0] n);
        return {6'h00, 2'h1, 8'(8'h50 + k), 10'h000, n, 1'b0, ~k[0], ~k[1], ~k[2]};
    endfunction
    initial begin
        #(40 * 5000);
        err_count++;
        tally_and_finish;
    end
    initial begin
        repeat (2) @(negedge clk_in);
        rst_in = 1'b0;
        rd(8'h10, 32'h00000000);
        rd(8'h11, 32'h00000000);
        rd(8'h1F, 32'h00000000);
        for (int k = 0; k < 8; k++) begin
            rd(8'(8'h20 + k), sw_word(k, 4'h0, 2'h0));
            rd(8'(8'h40 + k), pl_word(k, 2'h0));
            rd(8'(8'h80 + k), {4'h0, k[0], 27'h0000000});
            wr(8'(8'h20 + k), {20'hFFFFF, 4'(15 - k), 2'h3, 2'(k), 4'hF});
            rd(8'(8'h20 + k), sw_word(k, 4'(15 - k), 2'(k)));
            wr(8'(8'h40 + k), 32'hFFFFFFFF);
            rd(8'(8'h40 + k), pl_word(k, 2'h3));
            `CHK("pnet", 2'h3, pl_net[k])
            wr(8'(8'h80 + k), {1'b1, k[0], 5'h1F, 3'h7, 11'(k + 9), 11'(3 * k)});
            `CHK("pulses", 16'(16'h0101 << k), pls)
            `CHK("ctrl", {1'b1, k[0], 11'(k + 9), 11'(3 * k), 4'(15 - k), 2'(k)}, ctrl[k])
            repeat (2) @(negedge clk_in);
            rd(8'(8'h80 + k), {1'b1, k[0], 2'h0, k[0], 2'h3, 3'h0, 11'(k + 9), 11'(3 * k)});
            access(1'b1, 8'(8'h80 + k), 32'h00000000, 24'h0012FF);
            `CHK("noreply", 1'b0, got)
            `CHK("enable", 1'b0, ctrl[k].enable)
        end
        wr(8'h28, 32'hFFFFFFFF);
        rd(8'h28, 32'h00000000);
        rd(8'h88, 32'h00000000);
        wr(8'h10, 32'h00000003);
        wr(8'h11, 32'hFFFFFFFE);
        rd(8'h11, 32'h00000002);
        halted = 2'h2;
        repeat (4) @(negedge clk_in);
        `CHK("oe", 1'b0, pin_oe)
        `CHK("dreq", 2'h0, dbg_req)
        halted = 2'h1;
        repeat (3) @(negedge clk_in);
        `CHK("oe", 1'b1, pin_oe)
        `CHK("dreq", 2'h3, dbg_req)
        rd(8'h1F, 32'h00000001);
        halted = 2'h0;
        repeat (5) @(negedge clk_in);
        wr(8'h1F, 32'h00000000);
        ext_n = 1'b0;
        repeat (6) @(negedge clk_in);
        `CHK("dreq", 2'h3, dbg_req)
        rd(8'h1F, 32'h00000010);
        ext_n = 1'b1;
        wr(8'h11, 32'h00000003);
        repeat (4) @(negedge clk_in);
        wr(8'h1F, 32'h00000000);
        halted = 2'h2;
        repeat (3) @(negedge clk_in);
        rd(8'h1F, 32'h00000002);
        tally_and_finish;
    end
endmodule
`default_nettype wire
